// >>> design/lhig_top.sv
// Purpose: Host interrupt enable gating for channels 2 and 3
// Assumes: APB slave, pclk 40 MHz, inputs synchronous to pclk
// Notes: Local CPU only; the host has no register path
`timescale 1ns/1ps
module lhig_top
    import lhig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lpc_hw_reset,
    input wire logic lpc_sw_reset,
    input wire logic hw_standby,
    input wire logic host_out_data_reg_ch2_read,
    input wire logic [4:0] ch3_enable,
    input wire logic ch3_obf,
    output logic host_request_line_11,
    output logic host_request_line_10,
    output logic host_request_line_9,
    output logic host_request_line_6,
    output logic [4:0] ch3_request,
    output logic irq
);
`include "lhig_params.svh"

    lhig_top_s st_r;
    lhig_top_s st_nxt;

    logic [3:0] en2;
    logic [3:0] req2;
    logic acc;
    logic done;
    logic wr;
    logic rd;
    logic hit;
    logic en_rd;
    logic en_wr;
    logic lpc_rst;
    logic obf_set;
    logic obf_clr;
    logic en_clr;
    lhig_irq_t ev;

    // ======================================================
    // Bus decode
    assign acc = psel && penable;
    assign done = acc && st_r.pready;
    assign wr = done && pwrite;
    assign rd = done && !pwrite;
    assign en_rd = rd && (paddr == `LHIG_OFF_EN2);
    assign en_wr = wr && (paddr == `LHIG_OFF_EN2);

    always_comb
    begin
        if (paddr == `LHIG_OFF_EN2)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_SIRQ2)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_DIR2)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_OUT_DATA_REG_CH2)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_FLAG2)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_IST)
        begin
            hit = 1'b1;
        end
        else if (paddr == `LHIG_OFF_IMSK)
        begin
            hit = 1'b1;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // ======================================================
    // Buffer-full flag events
    assign lpc_rst = lpc_hw_reset || lpc_sw_reset;
    assign obf_set = wr && (paddr == `LHIG_OFF_OUT_DATA_REG_CH2);
    assign obf_clr = st_r.out_buffer_full_ch2 && !obf_set && (host_out_data_reg_ch2_read
        || (wr && (paddr == `LHIG_OFF_FLAG2)
        && !pwdata[`LHIG_BIT_OUT_BUFFER_FULL_CH2]));
    assign en_clr = lpc_rst || hw_standby
        || (obf_clr && !st_r.dir2);

    always_comb
    begin
        ev = '0;
        ev[`LHIG_IRQ_OBF_SET] = obf_set;
        ev[`LHIG_IRQ_OBF_CLR] = obf_clr;
        ev[`LHIG_IRQ_LPC_RST] = lpc_rst;
    end

    // ======================================================
    // Enable bits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_en
            lhig_en_bit u_bit (
                .pclk(pclk),
                .presetn(presetn),
                .rd_done(en_rd),
                .wr_done(en_wr),
                .wr_bit(pwdata[gi]),
                .clr(en_clr),
                .en(en2[gi])
            );
        end
    endgenerate

    // ======================================================
    // Request gating
    lhig_req_gate #(.N(4)) u_gate2 (
        .pclk(pclk),
        .presetn(presetn),
        .en(en2),
        .out_buffer_full(st_r.out_buffer_full_ch2),
        .direct(st_r.dir2),
        .req(req2)
    );

    lhig_req_gate #(.N(5)) u_gate3 (
        .pclk(pclk),
        .presetn(presetn),
        .en(ch3_enable),
        .out_buffer_full(ch3_obf),
        .direct(st_r.sirq2[`LHIG_BIT_DIR3]),
        .req(ch3_request)
    );

    assign host_request_line_11 = req2[3];
    assign host_request_line_10 = req2[2];
    assign host_request_line_9 = req2[1];
    assign host_request_line_6 = req2[0];

    // ======================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.phase = LHIG_PH_IDLE;
        if (acc && !st_r.pready)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.phase = LHIG_PH_ACK;
            st_nxt.pslverr = !hit;
            st_nxt.prdata = '0;
            if (!pwrite)
            begin
                if (paddr == `LHIG_OFF_EN2)
                begin
                    st_nxt.prdata[3:0] = en2;
                end
                else if (paddr == `LHIG_OFF_SIRQ2)
                begin
                    st_nxt.prdata[7:0] = st_r.sirq2;
                end
                else if (paddr == `LHIG_OFF_DIR2)
                begin
                    st_nxt.prdata[`LHIG_BIT_DIR2] = st_r.dir2;
                end
                else if (paddr == `LHIG_OFF_OUT_DATA_REG_CH2)
                begin
                    st_nxt.prdata[7:0] = st_r.out_data_reg_ch2;
                end
                else if (paddr == `LHIG_OFF_FLAG2)
                begin
                    st_nxt.prdata[`LHIG_BIT_OUT_BUFFER_FULL_CH2] = st_r.out_buffer_full_ch2;
                end
                else if (paddr == `LHIG_OFF_IST)
                begin
                    st_nxt.prdata[2:0] = st_r.ist;
                end
                else if (paddr == `LHIG_OFF_IMSK)
                begin
                    st_nxt.prdata[2:0] = st_r.imsk;
                end
            end
        end
        if (wr)
        begin
            if (paddr == `LHIG_OFF_SIRQ2)
            begin
                st_nxt.sirq2 = pwdata[7:0];
            end
            else if (paddr == `LHIG_OFF_DIR2)
            begin
                st_nxt.dir2 = pwdata[`LHIG_BIT_DIR2];
            end
            else if (paddr == `LHIG_OFF_OUT_DATA_REG_CH2)
            begin
                st_nxt.out_data_reg_ch2 = pwdata[7:0];
            end
            else if (paddr == `LHIG_OFF_IST)
            begin
                st_nxt.ist = st_r.ist & ~pwdata[2:0];
            end
            else if (paddr == `LHIG_OFF_IMSK)
            begin
                st_nxt.imsk = pwdata[2:0];
            end
        end
        if (obf_set)
        begin
            st_nxt.out_buffer_full_ch2 = 1'b1;
        end
        else if (obf_clr)
        begin
            st_nxt.out_buffer_full_ch2 = 1'b0;
        end
        st_nxt.ist = st_nxt.ist | ev;
        if (hw_standby)
        begin
            st_nxt.sirq2 = `LHIG_RST_SIRQ2;
            st_nxt.out_buffer_full_ch2 = 1'b0;
        end
        st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
    end

    // ======================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '{
                phase: LHIG_PH_IDLE,
                prdata: 32'h0000_0000,
                pready: 1'b0,
                pslverr: 1'b0,
                out_data_reg_ch2: `LHIG_RST_OUT_DATA_REG_CH2,
                out_buffer_full_ch2: 1'b0,
                dir2: 1'b0,
                sirq2: `LHIG_RST_SIRQ2,
                ist: `LHIG_RST_IRQ,
                imsk: `LHIG_RST_IRQ,
                irq: 1'b0
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ======================================================
    // Outputs
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq = st_r.irq;

endmodule

// >>> design/lhig_params.svh
// Purpose: Register offsets, field positions and reset values
// Assumes: Byte addresses on an APB bus with 32-bit data
// Notes: Definitions only
`ifndef LHIG_PARAMS_SVH
`define LHIG_PARAMS_SVH

// ==========================================================
// Register offsets
`define LHIG_OFF_EN2 8'h00
`define LHIG_OFF_SIRQ2 8'h04
`define LHIG_OFF_DIR2 8'h08
`define LHIG_OFF_OUT_DATA_REG_CH2 8'h0c
`define LHIG_OFF_FLAG2 8'h10
`define LHIG_OFF_IST 8'h14
`define LHIG_OFF_IMSK 8'h18

// ==========================================================
// Field positions
`define LHIG_BIT_DIR3 7
`define LHIG_BIT_DIR2 0
`define LHIG_BIT_OUT_BUFFER_FULL_CH2 0
`define LHIG_IRQ_OBF_SET 0
`define LHIG_IRQ_OBF_CLR 1
`define LHIG_IRQ_LPC_RST 2

// ==========================================================
// Reset values
`define LHIG_RST_SIRQ2 8'h00
`define LHIG_RST_EN 1'b0
`define LHIG_RST_OUT_DATA_REG_CH2 8'h00
`define LHIG_RST_IRQ 3'h0

`endif

// >>> design/lhig_pkg.sv
// Purpose: Types shared by the host interrupt gating block
// Assumes: Nothing
// Notes: Constants live in lhig_params.svh
package lhig_pkg;

    // ======================================================
    // Bus phase
    typedef enum logic [0:0] {
        LHIG_PH_IDLE = 1'b0,
        LHIG_PH_ACK = 1'b1
    } lhig_phase_e;

    typedef logic [2:0] lhig_irq_t;

    // ======================================================
    // Module state records
    typedef struct packed {
        logic armed;
        logic en;
    } lhig_bit_s;

    typedef struct packed {
        lhig_phase_e phase;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] out_data_reg_ch2;
        logic out_buffer_full_ch2;
        logic dir2;
        logic [7:0] sirq2;
        lhig_irq_t ist;
        lhig_irq_t imsk;
        logic irq;
    } lhig_top_s;

endpackage

// >>> design/lhig_en_bit.sv
// Purpose: One host interrupt enable bit with read-zero arming
// Assumes: Strobes are one-cycle pulses from the bus slave
// Notes: Hardware clear has priority over a write
`timescale 1ns/1ps
module lhig_en_bit
    import lhig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rd_done,
    input wire logic wr_done,
    input wire logic wr_bit,
    input wire logic clr,
    output logic en
);
`include "lhig_params.svh"

    lhig_bit_s st_r;
    lhig_bit_s st_nxt;

    // ======================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        if (rd_done)
        begin
            st_nxt.armed = ~st_r.en;
        end
        else if (wr_done)
        begin
            st_nxt.armed = 1'b0;
        end
        if (clr)
        begin
            st_nxt.en = 1'b0;
        end
        else if (wr_done && !wr_bit)
        begin
            st_nxt.en = 1'b0;
        end
        else if (wr_done && wr_bit && st_r.armed)
        begin
            st_nxt.en = 1'b1;
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '{armed: 1'b0, en: `LHIG_RST_EN};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign en = st_r.en;

endmodule

// >>> design/lhig_req_gate.sv
// Purpose: Gates enable bits with a buffer-full flag
// Assumes: Inputs synchronous to pclk
// Notes: Outputs registered
`timescale 1ns/1ps
module lhig_req_gate
    import lhig_pkg::*;
#(
    parameter int N = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] en,
    input wire logic out_buffer_full,
    input wire logic direct,
    output logic [N-1:0] req
);

    logic [N-1:0] req_r;
    logic [N-1:0] req_nxt;

    // ======================================================
    // Gating
    always_comb
    begin
        if (direct)
        begin
            req_nxt = en;
        end
        else
        begin
            req_nxt = en & {N{out_buffer_full}};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_r <= '0;
        end
        else
        begin
            req_r <= req_nxt;
        end
    end

    assign req = req_r;

endmodule

// >>> test/lhig_host_model.sv
// Purpose: Host side that reads data and issues LPC resets
// Assumes: Bench gives one-cycle go with kind and delay held
// Notes: Delay lets the host answer promptly or slowly
`timescale 1ns/1ps
module lhig_host_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [3:0] delay,
    output logic host_out_data_reg_ch2_read,
    output logic lpc_hw_reset,
    output logic lpc_sw_reset
);
    logic [3:0] cnt;
    logic busy;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            busy <= 1'b0;
            host_out_data_reg_ch2_read <= 1'b0;
            lpc_hw_reset <= 1'b0;
            lpc_sw_reset <= 1'b0;
        end
        else
        begin
            host_out_data_reg_ch2_read <= 1'b0;
            lpc_hw_reset <= 1'b0;
            lpc_sw_reset <= 1'b0;
            if (go)
            begin
                busy <= 1'b1;
                cnt <= delay;
            end
            else if (busy && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                host_out_data_reg_ch2_read <= (kind == 2'h0);
                lpc_hw_reset <= (kind == 2'h1);
                lpc_sw_reset <= (kind == 2'h2);
            end
        end
    end
endmodule

// >>> test/lhig_top_properties.sv
// Purpose: Port assertions for lhig_top
// Assumes: Bound to lhig_top
// Notes: Direct-mode bits shadowed from bus writes
`timescale 1ns/1ps
module lhig_top_properties
    import lhig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lpc_hw_reset,
    input wire logic lpc_sw_reset,
    input wire logic hw_standby,
    input wire logic host_out_data_reg_ch2_read,
    input wire logic [4:0] ch3_enable,
    input wire logic ch3_obf,
    input wire logic host_request_line_11,
    input wire logic host_request_line_10,
    input wire logic host_request_line_9,
    input wire logic host_request_line_6,
    input wire logic [4:0] ch3_request
);
    logic dir2;
    logic dir3;
    logic wr;
    logic [3:0] ln;
    assign wr = psel && penable && pready && pwrite;
    assign ln = {host_request_line_11, host_request_line_10,
        host_request_line_9, host_request_line_6};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir2 <= 1'b0;
            dir3 <= 1'b0;
        end
        else
        begin
            if (wr && paddr == 8'h08)
                dir2 <= pwdata[0];
            if (hw_standby)
                dir3 <= 1'b0;
            else if (wr && paddr == 8'h04)
                dir3 <= pwdata[7];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    chk_bad_addr: assert property (pready && paddr > 8'h18 |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("bad address");
    chk_rdata_hold: assert property (!pready |-> $stable(prdata))
        else $error("prdata moved");
    chk_lpc_clear: assert property (lpc_hw_reset || lpc_sw_reset |->
        ##2 ln == 4'h0) else $error("lpc reset kept request");
    chk_obf_clear: assert property (host_out_data_reg_ch2_read && !dir2 &&
        !(wr && paddr == 8'h0c) |-> ##2 ln == 4'h0)
        else $error("request after clear");
    chk_standby_clear: assert property (hw_standby |-> ##2 ln == 4'h0)
        else $error("standby kept request");
    chk_ch3_gate: assert property (1'b1 |=> ch3_request == ($past(dir3) ?
        $past(ch3_enable) : $past(ch3_enable) & {5{$past(ch3_obf)}}))
        else $error("ch3 request wrong");
endmodule

// >>> test/test_lpc_host_irq_enable_gating.sv
// Purpose: Self-checking bench for lhig_top
// Assumes: Seed 81, pclk 40 MHz
// Notes: Host pulses come from lhig_host_model
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    failures++; $display("unexpected at %0t: %h not %h", \
    $time, (a), (b)); end end
module test_lpc_host_irq_enable_gating;
    import lhig_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d, s;
    logic lpc_hw_reset, lpc_sw_reset, hw_standby, host_out_data_reg_ch2_read;
    logic ch3_obf, go, e;
    logic [4:0] ch3_enable, ch3_request;
    logic host_request_line_11, host_request_line_10;
    logic host_request_line_9, host_request_line_6;
    logic [1:0] kind;
    logic [3:0] dly, ln;
    int failures, comparisons, i;
    assign ln = {host_request_line_11, host_request_line_10,
        host_request_line_9, host_request_line_6};
    lhig_top dut (.*);
    lhig_host_model host (.pclk, .presetn, .go, .kind, .delay(dly),
        .host_out_data_reg_ch2_read, .lpc_hw_reset, .lpc_sw_reset);
    function automatic logic [4:0] want(logic m, logic [4:0] n, logic o);
        return m ? n : (n & {5{o}});
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] v, output logic [31:0] r, output logic x);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        `CHK(pready, 1'b1)
        r = prdata;
        x = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic y;
        apb(1'b0, a, 32'h0, r, y);
        `CHK(r, x)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        logic y;
        apb(1'b1, a, v, r, y);
    endtask
    task automatic hst(input logic [1:0] k, input logic [3:0] t);
        @(posedge pclk);
        kind <= k;
        dly <= t;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial
    begin
        #400000;
        failures++;
        tally_and_finish();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, hw_standby, ch3_obf, go} = 7'h0;
        {paddr, pwdata, ch3_enable, kind, dly} = 51'h0;
        d = $urandom(81);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 7; i++)
            rd(8'(i * 4), 32'h0);
        apb(1'b0, 8'h40, 32'h0, d, e);
        `CHK({e, d}, 33'h100000000)
        wr(8'h00, 32'h0);
        wr(8'h00, 32'hf);
        rd(8'h00, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            d = $urandom;
            rd(8'h00, 32'h0);
            wr(8'h00, 32'h1 << i);
            wr(8'h0c, {24'h0, d[7:0]});
            rd(8'h10, 32'h1);
            `CHK(ln, 4'(1 << i))
            hst(2'h0, d[11:8]);
            rd(8'h00, 32'h0);
        end
        wr(8'h08, 32'h1);
        for (i = 1; i < 3; i++)
        begin
            d = 32'($urandom_range(15, 1));
            rd(8'h00, 32'h0);
            wr(8'h00, d);
            rd(8'h00, d);
            `CHK(ln, d[3:0])
            wr(8'h0c, 32'h0);
            wr(8'h10, 32'h0);
            rd(8'h00, d);
            wr(8'h00, 32'h0);
            rd(8'h00, 32'h0);
            wr(8'h00, d);
            hst(2'(i), 4'h3);
            rd(8'h00, 32'h0);
        end
        wr(8'h08, 32'h0);
        for (i = 0; i < 2; i++)
        begin
            s = i ? 32'h7f : 32'h80;
            wr(8'h04, s);
            rd(8'h04, s);
            repeat (10)
            begin
                d = $urandom;
                @(posedge pclk);
                ch3_enable <= d[4:0];
                ch3_obf <= d[5];
                repeat (2) @(posedge pclk);
                `CHK(ch3_request, want(!i, d[4:0], d[5]))
            end
        end
        @(posedge pclk);
        hw_standby <= 1'b1;
        @(posedge pclk);
        hw_standby <= 1'b0;
        rd(8'h04, 32'h0);
        wr(8'h14, 32'h7);
        rd(8'h14, 32'h0);
        wr(8'h18, 32'h1);
        wr(8'h0c, 32'h5a);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(8'h18, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        wr(8'h18, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(8'h14, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        hst(2'h0, 4'h0);
        `CHK(irq, 1'b1)
        rd(8'h14, 32'h2);
        tally_and_finish();
    end
endmodule
bind lhig_top lhig_top_properties chk (.*);
